// [core/gcs_global_regs.v]
// Global configuration, status, input snapshot and OTP entry registers
`timescale 1ns/10ps
`default_nettype none
`include "gcs_defines.vh"

// Functional notes
// - Configuration bit 14 picks a step-rate hysteresis of 1/16 when clear and 1/32 when set.
// - With bit 15 set and the emergency stop input high, the sequencer halts and the motor is held at standstill.
// - With bit 16 set, coil currents come from register 0x2D, signed coil A in the low bits and coil B from bit 16.
// - Bit 17 routes an analog test signal chosen by the low hold current bits to the test pin; software keeps it 0.
// - Writing a 1 to a status bit at 0x01 clears that flag, a 0 leaves it alone.
// - Status bit 0 is set after reset, when all registers hold their reset values.
// - Status bit 1 sets on a driver shutdown and clears only once the temperature is back below the limit.
// - Status bit 2 latches a charge pump undervoltage and the driver stays off while it lasts.
// - Register 0x04 reads the live pins: step, direction, rate enable, rate input, enable-low, test cfg, bit 6 one.
// - Bits 31 to 24 of register 0x04 hold a fixed version code.
// - A write to 0x06 programs one OTP bit, and only when bits 15 to 8 carry the magic value.
module gcs_global_regs
#(
    parameter [7:0] VERSION_CODE = 8'h5a     // Arbitrary value
)
(
    input  wire                           clk_sys,
    input  wire                           reset,
    // Register port from the serial interface
    input  wire                           reg_wr_en,
    input  wire                           reg_rd_en,
    input  wire [6:0]                     reg_addr,
    input  wire [31:0]                    reg_wdata,
    output reg  [31:0]                    reg_rdata_r,
    output reg                            reg_rdata_valid_r,
    // Live pins
    input  wire                           step_pin,
    input  wire                           dir_pin,
    input  wire                           step_rate_enable_pin,
    input  wire                           step_rate_input_pin,
    input  wire                           driver_enable_low_pin,
    input  wire                           test_output_cfg_pin,
    input  wire                           emergency_stop_input,
    // Protection and settings from the rest of the device
    input  wire                           drv_shutdown,
    input  wire                           temp_below_limit,
    input  wire                           pump_undervoltage,
    input  wire [`GCS_HOLD_W-1:0]         hold_current_setting,
    input  wire [`GCS_REF_W-1:0]          step_rate_ref,
    // Controls to the rest of the device
    output reg  [`GCS_REF_W-1:0]          step_hyst_r,
    output reg                            seq_halt_r,
    output reg                            standstill_force_r,
    output reg                            coil_direct_r,
    output reg  signed [`GCS_COIL_W-1:0]  coil_a_r,
    output reg  signed [`GCS_COIL_W-1:0]  coil_b_r,
    output reg                            auto_current_reg_en_r,
    output reg                            test_out_en_r,
    output reg  [1:0]                     test_sel_r,
    output reg                            driver_outputs_en_r,
    output reg  [`GCS_STAT_W-1:0]         global_status_flags_r,
    output reg                            otp_program_control_pulse_r,
    output reg  [2:0]                     otp_bit_sel_r,
    output reg  [1:0]                     otp_byte_sel_r
);

    ////////////////////////////////////////////////////////////////////////////
    // Address match shared by read and write paths
    function addr_hit;
        input [6:0] addr;
        input [6:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    reg  [`GCS_CFG_W-1:0]    cfg_r;
    reg  [`GCS_CFG_W-1:0]    cfg_nxt;
    reg  [31:0]              coil_reg_r;
    reg  [31:0]              coil_reg_nxt;
    reg  [`GCS_STAT_W-1:0]   stat_nxt;
    reg  [31:0]              rdata_nxt;

    wire                     wr_cfg;
    wire                     wr_stat;
    wire                     wr_otp;
    wire                     wr_coil;
    wire [31:0]              pin_word;
    wire                     otp_magic_ok;
    wire signed [`GCS_COIL_W-1:0] coil_a_raw;
    wire signed [`GCS_COIL_W-1:0] coil_b_raw;
    wire signed [`GCS_COIL_W-1:0] coil_a_scaled;
    wire signed [`GCS_COIL_W-1:0] coil_b_scaled;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode
    assign wr_cfg  = reg_wr_en & addr_hit(reg_addr, `GCS_ADDR_CFG);
    assign wr_stat = reg_wr_en & addr_hit(reg_addr, `GCS_ADDR_STAT);
    assign wr_otp  = reg_wr_en & addr_hit(reg_addr, `GCS_ADDR_OTP_CTL);
    assign wr_coil = reg_wr_en & addr_hit(reg_addr, `GCS_ADDR_COIL);

    // Magic value gates every OTP write
    assign otp_magic_ok = (reg_wdata[`GCS_OTP_MAGIC_MSB:`GCS_OTP_MAGIC_LSB] == `GCS_OTP_MAGIC);

    ////////////////////////////////////////////////////////////////////////////
    // Input snapshot word from live pins
    assign pin_word  = {VERSION_CODE,
                        16'h0000,
                        1'b0,
                        1'b1,
                        test_output_cfg_pin,
                        driver_enable_low_pin,
                        step_rate_input_pin,
                        step_rate_enable_pin,
                        dir_pin,
                        step_pin};

    ////////////////////////////////////////////////////////////////////////////
    // Direct coil values and their scaling by the hold current
    assign coil_a_raw = coil_reg_r[`GCS_XD_A_MSB:`GCS_XD_A_LSB];
    assign coil_b_raw = coil_reg_r[`GCS_XD_B_MSB:`GCS_XD_B_LSB];

    gcs_coil_scale u_scale_a
    (
        .coil_in              (coil_a_raw),
        .hold_current_setting (hold_current_setting),
        .coil_out             (coil_a_scaled)
    );

    gcs_coil_scale u_scale_b
    (
        .coil_in              (coil_b_raw),
        .hold_current_setting (hold_current_setting),
        .coil_out             (coil_b_scaled)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and direct coil register next values
    always @*
    begin
        cfg_nxt      = cfg_r;
        coil_reg_nxt = coil_reg_r;
        if (wr_cfg)
        begin
            cfg_nxt = reg_wdata[`GCS_CFG_W-1:0];
        end
        if (wr_coil)
        begin
            coil_reg_nxt = reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags: hardware set wins over a write-one clear
    always @*
    begin
        stat_nxt = global_status_flags_r;
        // Reset indication only clears by software
        if (wr_stat && reg_wdata[`GCS_STAT_RESET])
        begin
            stat_nxt[`GCS_STAT_RESET] = 1'b0;
        end
        // Driver error clears only once cooled down
        if (wr_stat && reg_wdata[`GCS_STAT_DRV_ERR] && temp_below_limit)
        begin
            stat_nxt[`GCS_STAT_DRV_ERR] = 1'b0;
        end
        if (drv_shutdown)
        begin
            stat_nxt[`GCS_STAT_DRV_ERR] = 1'b1;
        end
        // Undervoltage latches
        if (wr_stat && reg_wdata[`GCS_STAT_PUMP_UV])
        begin
            stat_nxt[`GCS_STAT_PUMP_UV] = 1'b0;
        end
        if (pump_undervoltage)
        begin
            stat_nxt[`GCS_STAT_PUMP_UV] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; write-only and unmapped addresses read zero
    always @*
    begin
        rdata_nxt = `GCS_ZERO32;
        if (addr_hit(reg_addr, `GCS_ADDR_CFG))
        begin
            rdata_nxt = {14'h0000, cfg_r};
        end
        else if (addr_hit(reg_addr, `GCS_ADDR_STAT))
        begin
            rdata_nxt = {29'h00000000, global_status_flags_r};
        end
        else if (addr_hit(reg_addr, `GCS_ADDR_PINS))
        begin
            rdata_nxt = pin_word;
        end
        else if (addr_hit(reg_addr, `GCS_ADDR_COIL))
        begin
            rdata_nxt = coil_reg_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register state and read answer
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            cfg_r                 <= `GCS_CFG_RST;
            coil_reg_r            <= `GCS_COIL_REG_RST;
            global_status_flags_r <= `GCS_STAT_RST;
            reg_rdata_r           <= `GCS_ZERO32;
            reg_rdata_valid_r     <= 1'b0;
        end
        else
        begin
            cfg_r                 <= cfg_nxt;
            coil_reg_r            <= coil_reg_nxt;
            global_status_flags_r <= stat_nxt;
            reg_rdata_valid_r     <= reg_rd_en;
            if (reg_rd_en)
            begin
                reg_rdata_r <= rdata_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Step rate hysteresis from the selected fraction
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            step_hyst_r <= {`GCS_REF_W{1'b0}};
        end
        else if (cfg_r[`GCS_CFG_SMALL_HYST])
        begin
            step_hyst_r <= step_rate_ref >> `GCS_HYST_SHIFT_SMALL;
        end
        else
        begin
            step_hyst_r <= step_rate_ref >> `GCS_HYST_SHIFT_WIDE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Emergency stop, driver enable and test output controls
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            seq_halt_r          <= 1'b0;
            standstill_force_r  <= 1'b0;
            driver_outputs_en_r <= 1'b0;
            test_out_en_r       <= 1'b0;
            test_sel_r          <= 2'h0;
        end
        else
        begin
            seq_halt_r          <= cfg_r[`GCS_CFG_STOP_EN] & emergency_stop_input;
            standstill_force_r  <= cfg_r[`GCS_CFG_STOP_EN] & emergency_stop_input;
            driver_outputs_en_r <= ~pump_undervoltage & ~drv_shutdown;
            test_out_en_r       <= cfg_r[`GCS_CFG_TEST];
            test_sel_r          <= hold_current_setting[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Direct coil current outputs
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            coil_direct_r         <= 1'b0;
            coil_a_r              <= {`GCS_COIL_W{1'b0}};
            coil_b_r              <= {`GCS_COIL_W{1'b0}};
            auto_current_reg_en_r <= 1'b1;
        end
        else
        begin
            coil_direct_r         <= cfg_r[`GCS_CFG_DIRECT];
            auto_current_reg_en_r <= ~cfg_r[`GCS_CFG_DIRECT];
            if (cfg_r[`GCS_CFG_DIRECT])
            begin
                coil_a_r <= coil_a_scaled;
                coil_b_r <= coil_b_scaled;
            end
            else
            begin
                coil_a_r <= {`GCS_COIL_W{1'b0}};
                coil_b_r <= {`GCS_COIL_W{1'b0}};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // OTP program request: one pulse per accepted write
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            otp_program_control_pulse_r <= 1'b0;
            otp_bit_sel_r    <= 3'h0;
            otp_byte_sel_r   <= 2'h0;
        end
        else
        begin
            otp_program_control_pulse_r <= wr_otp & otp_magic_ok;
            if (wr_otp && otp_magic_ok)
            begin
                otp_bit_sel_r  <= reg_wdata[`GCS_OTP_BIT_MSB:`GCS_OTP_BIT_LSB];
                otp_byte_sel_r <= reg_wdata[`GCS_OTP_BYTE_MSB:`GCS_OTP_BYTE_LSB];
            end
        end
    end

endmodule // gcs_global_regs

`default_nettype wire

// [core/gcs_defines.vh]
// Constants for the global configuration and status register bank
`ifndef GCS_DEFINES_VH
`define GCS_DEFINES_VH

// Register addresses on the serial register port
`define GCS_ADDR_CFG         7'h00
`define GCS_ADDR_STAT        7'h01
`define GCS_ADDR_PINS        7'h04
`define GCS_ADDR_OTP_CTL     7'h06
`define GCS_ADDR_COIL        7'h2d

// Register widths
`define GCS_CFG_W            18
`define GCS_STAT_W           3
`define GCS_COIL_W           9
`define GCS_HOLD_W           5
`define GCS_REF_W            20

// Configuration bit positions
`define GCS_CFG_SMALL_HYST   14
`define GCS_CFG_STOP_EN      15
`define GCS_CFG_DIRECT       16
`define GCS_CFG_TEST         17

// Status bit positions
`define GCS_STAT_RESET       0
`define GCS_STAT_DRV_ERR     1
`define GCS_STAT_PUMP_UV     2

// Coil field positions in the direct coil current register
`define GCS_XD_A_LSB         0
`define GCS_XD_A_MSB         8
`define GCS_XD_B_LSB         16
`define GCS_XD_B_MSB         24

// Input snapshot layout
`define GCS_PINS_ONE_BIT     6
`define GCS_PINS_VER_LSB     24
`define GCS_PINS_VER_MSB     31

// OTP programming fields
`define GCS_OTP_BIT_LSB      0
`define GCS_OTP_BIT_MSB      2
`define GCS_OTP_BYTE_LSB     4
`define GCS_OTP_BYTE_MSB     5
`define GCS_OTP_MAGIC_LSB    8
`define GCS_OTP_MAGIC_MSB    15
`define GCS_OTP_MAGIC        8'hbd

// Hysteresis shifts: 1/16 and 1/32
`define GCS_HYST_SHIFT_WIDE  5'h04
`define GCS_HYST_SHIFT_SMALL 5'h05

// Reset values
`define GCS_CFG_RST          18'h00000
`define GCS_STAT_RST         3'h1
`define GCS_COIL_REG_RST     32'h00000000
`define GCS_ZERO32           32'h00000000

`endif

// [core/gcs_coil_scale.v]
// Coil current scaler: signed coil value times (hold setting + 1) / 32
`timescale 1ns/10ps
`default_nettype none
`include "gcs_defines.vh"

module gcs_coil_scale
(
    input  wire signed [`GCS_COIL_W-1:0]  coil_in,
    input  wire        [`GCS_HOLD_W-1:0]  hold_current_setting,
    output wire signed [`GCS_COIL_W-1:0]  coil_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Scale factor runs 1..32; full scale at the top hold setting
    wire        [5:0]  scale_fac;
    wire signed [15:0] product;

    assign scale_fac = {1'b0, hold_current_setting} + 6'h01;
    assign product   = coil_in * $signed({1'b0, scale_fac});
    assign coil_out  = product[13:5];   // Divide by 32, never overflows

endmodule // gcs_coil_scale

`default_nettype wire

// [test/gcs_global_regs_monitor.sv]
// Port checker for the global configuration and status register bank
`timescale 1ns/10ps
`default_nettype none
module gcs_global_regs_monitor
(
    input wire logic               clk_sys,
    input wire logic               reset,
    input wire logic               reg_wr_en,
    input wire logic               reg_rd_en,
    input wire logic [6:0]         reg_addr,
    input wire logic [31:0]        reg_wdata,
    input wire logic [31:0]        reg_rdata_r,
    input wire logic               reg_rdata_valid_r,
    input wire logic               emergency_stop_input,
    input wire logic               drv_shutdown,
    input wire logic               pump_undervoltage,
    input wire logic [19:0]        step_rate_ref,
    input wire logic [19:0]        step_hyst_r,
    input wire logic               seq_halt_r,
    input wire logic               coil_direct_r,
    input wire logic signed [8:0]  coil_a_r,
    input wire logic               auto_current_reg_en_r,
    input wire logic               driver_outputs_en_r,
    input wire logic [2:0]         global_status_flags_r,
    input wire logic               otp_program_control_pulse_r
);
    default clocking gcs_cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////
    // Read answer and data hold
    property p_rd_valid; !$past(reset) |-> reg_rdata_valid_r == $past(reg_rd_en); endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read answer timing wrong");
    property p_rd_hold; !reg_rd_en |=> $stable(reg_rdata_r); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    // Control outputs derived from configuration
    property p_hyst; !$past(reset) |-> step_hyst_r == $past(step_rate_ref) >> 4
        || step_hyst_r == $past(step_rate_ref) >> 5; endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis not a sixteenth or a thirty-second");
    property p_halt; seq_halt_r |-> $past(emergency_stop_input); endproperty
    a_halt: assert property (p_halt) else $error("halt without stop input");
    property p_auto; auto_current_reg_en_r != coil_direct_r; endproperty
    a_auto: assert property (p_auto) else $error("auto regulation active in direct mode");
    property p_coil_off; !coil_direct_r |-> coil_a_r == 9'h000; endproperty
    a_coil_off: assert property (p_coil_off) else $error("coil value outside direct mode");
    // Status flags and driver enable
    property p_drv_en; !$past(reset) |-> driver_outputs_en_r ==
        !($past(pump_undervoltage) || $past(drv_shutdown)); endproperty
    a_drv_en: assert property (p_drv_en) else $error("driver enable wrong");
    property p_uv_latch; pump_undervoltage |=> global_status_flags_r[2]; endproperty
    a_uv_latch: assert property (p_uv_latch) else $error("undervoltage flag not set");
    property p_err_set; drv_shutdown |=> global_status_flags_r[1]; endproperty
    a_err_set: assert property (p_err_set) else $error("driver error flag not set");
    property p_w1c; reg_wr_en && reg_addr == 7'h01 && reg_wdata[0] |=> !global_status_flags_r[0]; endproperty
    a_w1c: assert property (p_w1c) else $error("reset flag not cleared");
    // OTP entry
    property p_otp_ok; reg_wr_en && reg_addr == 7'h06 && reg_wdata[15:8] == 8'hbd |=> otp_program_control_pulse_r; endproperty
    a_otp_ok: assert property (p_otp_ok) else $error("otp write not accepted");
    property p_otp_no; reg_wr_en && reg_addr == 7'h06 && reg_wdata[15:8] != 8'hbd |=> !otp_program_control_pulse_r; endproperty
    a_otp_no: assert property (p_otp_no) else $error("otp write without key accepted");
    // Main scenarios reached
    c_read: cover property (reg_rd_en ##1 reg_rdata_valid_r);
    c_otp: cover property (otp_program_control_pulse_r);
    c_direct: cover property (coil_direct_r && coil_a_r != 9'h000);
    c_halt: cover property (seq_halt_r);
endmodule // gcs_global_regs_monitor
`default_nettype wire

// [test/gcs_host.sv]
// Host model driving the register port of the bank
`timescale 1ns/10ps
`default_nettype none
module gcs_host
(
    input  wire logic        clk_sys,
    output var  logic        reg_wr_en,
    output var  logic        reg_rd_en,
    output var  logic [6:0]  reg_addr,
    output var  logic [31:0] reg_wdata,
    input  wire logic [31:0] reg_rdata_r,
    input  wire logic        reg_rdata_valid_r
);
    // Idle port at time zero
    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 7'h7f;
        reg_wdata = 32'h0;
    end
    // One write strobe; afterwards the idle bus shows inverted values
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // One read strobe, then a bounded wait for the answer
    task automatic rd(input logic [6:0] a, output logic [31:0] d, output logic ok);
        integer n;
        @(posedge clk_sys);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        ok = 1'b0;
        d = 32'h0;
        for (n = 0; n < 4 && !ok; n++)
        begin
            #1;
            if (reg_rdata_valid_r === 1'b1)
            begin
                ok = 1'b1;
                d = reg_rdata_r;
            end
            else
                @(posedge clk_sys);
        end
    endtask
endmodule // gcs_host
`default_nettype wire

// [test/global_config_status_regs_tb_top.sv]
// Testbench for the global configuration and status register bank
`timescale 1ns/10ps
`default_nettype none
module global_config_status_regs_tb_top;
    localparam logic [7:0] VER = 8'ha7; // Arbitrary version value
    typedef struct packed {logic [6:0] wa; logic [31:0] wd; logic [6:0] ra; logic [31:0] ex;} gcs_row_t;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [5:0] pins = 6'h2d;
    logic emergency_stop_input = 1'b0, drv_shutdown = 1'b0, temp_below_limit = 1'b0, pump_undervoltage = 1'b0;
    logic [4:0] hold_current_setting = 5'h0e;
    logic [19:0] step_rate_ref = 20'h12345;
    wire logic reg_wr_en, reg_rd_en, reg_rdata_valid_r, seq_halt_r, standstill_force_r, coil_direct_r;
    wire logic auto_current_reg_en_r, test_out_en_r, driver_outputs_en_r, otp_program_control_pulse_r;
    wire logic [6:0] reg_addr;
    wire logic [31:0] reg_wdata, reg_rdata_r;
    wire logic [19:0] step_hyst_r;
    wire logic signed [8:0] coil_a_r, coil_b_r;
    wire logic [1:0] test_sel_r, otp_byte_sel_r;
    wire logic [2:0] global_status_flags_r, otp_bit_sel_r;
    int err_count = 0;
    int check_count = 0;
    // Write, then read back: address, data, read address, expected word
    gcs_row_t rows [5] = '{
        '{7'h00, 32'hffffffff, 7'h00, 32'h0003ffff},
        '{7'h00, 32'h00000000, 7'h00, 32'h00000000},
        '{7'h04, 32'hffffffff, 7'h04, {VER, 16'h0000, 2'b01, 6'h2d}},
        '{7'h7f, 32'hffffffff, 7'h06, 32'h00000000},
        '{7'h06, 32'h0000ffff, 7'h7f, 32'h00000000}};
    ////////////////////////////////////////////////////////////////////////////
    gcs_global_regs #(.VERSION_CODE(VER)) u_dut
    (
        .clk_sys, .reset, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata_r, .reg_rdata_valid_r,
        .step_pin(pins[0]), .dir_pin(pins[1]), .step_rate_enable_pin(pins[2]), .step_rate_input_pin(pins[3]),
        .driver_enable_low_pin(pins[4]), .test_output_cfg_pin(pins[5]), .emergency_stop_input, .drv_shutdown,
        .temp_below_limit, .pump_undervoltage, .hold_current_setting, .step_rate_ref, .step_hyst_r, .seq_halt_r,
        .standstill_force_r, .coil_direct_r, .coil_a_r, .coil_b_r, .auto_current_reg_en_r, .test_out_en_r,
        .test_sel_r, .driver_outputs_en_r, .global_status_flags_r, .otp_program_control_pulse_r, .otp_bit_sel_r, .otp_byte_sel_r
    );
    gcs_host u_host (.clk_sys, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata_r, .reg_rdata_valid_r);
    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic chk_rd(input logic [6:0] a, input logic [31:0] ex);
        logic [31:0] d;
        logic ok;
        u_host.rd(a, d, ok);
        if (!ok)
        begin
            err_count++;
            summarize();
        end
        else
            chk($sformatf("read %h", a), ex, d);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        chk_rd(7'h01, 32'h1);
        chk_rd(7'h00, 32'h0);
        chk("auto regulation", 32'h1, auto_current_reg_en_r);
        // Table of plain accesses
        foreach (rows[i])
        begin
            u_host.wr(rows[i].wa, rows[i].wd);
            chk_rd(rows[i].ra, rows[i].ex);
        end
        // Pins are read live
        @(posedge clk_sys);
        pins <= 6'h12;
        chk_rd(7'h04, {VER, 16'h0000, 2'b01, 6'h12});
        // Clear by writing one only
        u_host.wr(7'h01, 32'h0);
        chk_rd(7'h01, 32'h1);
        u_host.wr(7'h01, 32'h1);
        chk_rd(7'h01, 32'h0);
        // Driver error clears only when cool
        @(posedge clk_sys);
        drv_shutdown <= 1'b1;
        @(posedge clk_sys);
        drv_shutdown <= 1'b0;
        u_host.wr(7'h01, 32'h2);
        chk_rd(7'h01, 32'h2);
        @(posedge clk_sys);
        temp_below_limit <= 1'b1;
        u_host.wr(7'h01, 32'h2);
        chk_rd(7'h01, 32'h0);
        // Undervoltage disables driver and latches
        @(posedge clk_sys);
        pump_undervoltage <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 chk("driver enable", 32'h0, driver_outputs_en_r);
        @(posedge clk_sys);
        pump_undervoltage <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk("driver enable", 32'h1, driver_outputs_en_r);
        chk_rd(7'h01, 32'h4);
        // Direct coil mode, small hysteresis and test output
        u_host.wr(7'h2d, 32'h01c00040);
        u_host.wr(7'h00, 32'h00034000);
        repeat (2) @(posedge clk_sys);
        #1 chk("hysteresis", 32'h0091a, step_hyst_r);
        chk("direct mode", 32'h1, coil_direct_r);
        chk("coil a", 32'h01e, {23'h0, coil_a_r});
        chk("coil b", 32'h1e2, {23'h0, coil_b_r});
        chk("auto regulation", 32'h0, auto_current_reg_en_r);
        chk("test enable", 32'h1, test_out_en_r);
        chk("test select", 32'h2, test_sel_r);
        // Emergency stop with wide hysteresis; test mode back off
        @(posedge clk_sys);
        emergency_stop_input <= 1'b1;
        u_host.wr(7'h00, 32'h00008000);
        repeat (2) @(posedge clk_sys);
        #1 chk("halt", 32'h1, seq_halt_r);
        chk("standstill", 32'h1, standstill_force_r);
        chk("hysteresis", 32'h01234, step_hyst_r);
        chk("coil a", 32'h0, {23'h0, coil_a_r});
        u_host.wr(7'h00, 32'h00004000);
        repeat (2) @(posedge clk_sys);
        #1 chk("halt", 32'h0, seq_halt_r);
        // OTP entry with and without key
        u_host.wr(7'h06, 32'h0000bd13);
        #1 chk("otp pulse", 32'h1, otp_program_control_pulse_r);
        chk("otp bit", 32'h3, otp_bit_sel_r);
        chk("otp byte", 32'h1, otp_byte_sel_r);
        @(posedge clk_sys);
        #1 chk("otp pulse", 32'h0, otp_program_control_pulse_r);
        u_host.wr(7'h06, 32'h0000bc13);
        #1 chk("otp pulse", 32'h0, otp_program_control_pulse_r);
        // Reset in mid-run
        @(posedge clk_sys);
        reset <= 1'b1;
        @(posedge clk_sys);
        reset <= 1'b0;
        chk_rd(7'h01, 32'h1);
        chk_rd(7'h00, 32'h0);
        summarize();
    end
endmodule // global_config_status_regs_tb_top
bind gcs_global_regs gcs_global_regs_monitor u_mon
(
    .clk_sys, .reset, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata_r, .reg_rdata_valid_r,
    .emergency_stop_input, .drv_shutdown, .pump_undervoltage, .step_rate_ref, .step_hyst_r, .seq_halt_r,
    .coil_direct_r, .coil_a_r, .auto_current_reg_en_r, .driver_outputs_en_r, .global_status_flags_r,
    .otp_program_control_pulse_r
);
`default_nettype wire
